// >>> scu_ctrl_exec.sv
/*
 * Execution unit for the system-control instruction group of an 8-bit
 * core: call, jump, computed jump, the three returns, interrupt enable
 * and disable, watchdog clear, no-operation, software reset and the two
 * halt modes. Registers are reached over a classic Wishbone slave.
 * Assumes a decoder presents one control instruction at a time with its
 * target and immediate, and that the oscillator, watchdog, clock gate and
 * reset tree act on the strobes driven here.
 */
// Chosen here: the Wishbone interface to the registers and the address map.
// Function
// - Call stacks next address, jumps, sp plus 2
// - Jump loads full-range target into counter
// - Return-with-value writes immediate, then returns
// - Return: sp minus 2, reload counter
// - Interrupt return also sets interrupt enable
// - Flags never change; no-op only advances
// - Watchdog clear restarts watchdog count
// - Computed jump adds working register
// - Interrupt-on sets global interrupt enable
// - Interrupt-off clears global interrupt enable
// - System halt stops all clocks
// - Core halt gates core clock, oscillators run
// - Software reset equals hardware reset
// - Branches and returns take two cycles
`timescale 1ns/10ps
`default_nettype none

module scu_ctrl_exec
  import scu_pkg::*;
#(
  parameter int PC_W = 12,               // Program address width
  parameter int SP_W = 8,                // Stack pointer width
  parameter int STACK_DEPTH = 8          // Return entries held
) (
  input wire logic clk_i,
  input wire logic rst_i,
  // Instruction side
  input wire logic instr_valid_i,
  output logic instr_ready_o,
  input wire logic [3:0] instr_op_i,
  input wire logic [PC_W-1:0] instr_target_i,
  input wire logic [7:0] instr_imm_i,
  input wire logic [7:0] working_register_i,
  output logic [PC_W-1:0] pc_o,
  output logic [SP_W-1:0] stack_top_pointer_o,
  output logic fetch_flush_o,
  output logic working_register_we_o,
  output logic [7:0] working_register_o,
  output logic flags_we_o,
  // System strobes
  output logic gie_o,
  output logic wdt_clear_o,
  output logic sys_halt_o,
  output logic core_clk_gate_o,
  output logic chip_reset_o,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o
);

  localparam int IDX_W = $clog2(STACK_DEPTH); // Stack entry index width
  localparam int SP_LSB = $clog2(SCU_SP_STEP); // Byte-to-entry shift

  // ************************************************************
  // State
  // ************************************************************
  typedef struct packed {
    scu_state_e st;                      // Sequencer
    logic [PC_W-1:0] pc;                 // Program counter
    logic [SP_W-1:0] sp;                 // Stack pointer, bytes
    logic gie;                           // Global interrupt enable
    logic ret_int;                       // Current return is reti
    logic halt_sys;                      // Whole system stopped
    logic halt_core;                     // Core clock gated
    logic flush;                         // Drop prefetched word
    logic wdt_clr;                       // Watchdog restart pulse
    logic chip_rst;                      // Software reset pulse
    logic acc_we;                        // Working register write
    logic [7:0] acc;                     // Value for working register
    logic ack;                           // Bus acknowledge
    logic [31:0] rdata;                  // Bus read data
  } scu_state_s;

  scu_state_s q;                         // Registered state
  scu_state_s next_q;                    // Next state
  scu_state_s rst_val;                   // Value after any reset

  // Stack store ports
  logic ram_we;
  logic [IDX_W-1:0] ram_waddr;
  logic [IDX_W-1:0] ram_raddr;
  logic [PC_W-1:0] ram_rdata;
  logic [PC_W-1:0] pc_seq;               // Sequential next counter
  logic [SP_W-1:0] sp_up;                // Pointer after a push
  logic [SP_W-1:0] sp_dn;                // Pointer after a pop
  logic bus_req;                         // New bus cycle this clock
  logic take;                            // Instruction accepted
  scu_op_e op;                           // Decoded operation

  // ************************************************************
  // Return address store
  // ************************************************************
  scu_stack_ram #(
    .WIDTH(PC_W),
    .DEPTH(STACK_DEPTH)
  ) u_stack (
    .clk_i(clk_i),
    .we_i(ram_we),
    .waddr_i(ram_waddr),
    .wdata_i(pc_seq),
    .raddr_i(ram_raddr),
    .rdata_o(ram_rdata)
  );

  // ************************************************************
  // Helpers
  // ************************************************************
  // Counter and pointer arithmetic, cut to width on purpose
  always_comb
  begin
    pc_seq = q.pc + PC_W'(SCU_PC_STEP);
    sp_up = q.sp + SP_W'(SCU_SP_STEP);
    sp_dn = q.sp - SP_W'(SCU_SP_STEP);
    op = scu_op_e'(instr_op_i);
    bus_req = wb_cyc_i && wb_stb_i && !q.ack;
    instr_ready_o = (q.st == SCU_ST_IDLE) && !q.halt_sys && !q.halt_core;
    take = instr_valid_i && instr_ready_o;
  end

  // Reset image, shared by hardware and software reset
  always_comb
  begin
    rst_val = '0;
    rst_val.st = SCU_ST_IDLE;
    rst_val.gie = SCU_GIE_RST;
  end

  // ************************************************************
  // Next-state logic
  // ************************************************************
  always_comb
  begin
    next_q = q;
    // Pulses last one cycle
    next_q.flush = 1'b0;
    next_q.wdt_clr = 1'b0;
    next_q.chip_rst = 1'b0;
    next_q.acc_we = 1'b0;
    next_q.ack = 1'b0;
    ram_we = 1'b0;
    ram_waddr = q.sp[SP_LSB +: IDX_W];
    ram_raddr = sp_dn[SP_LSB +: IDX_W];

    // Bus slave: answers every address, unmapped ones read zero
    if (bus_req)
    begin
      next_q.ack = 1'b1;
      next_q.rdata = '0;
      if (wb_we_i)
      begin
        if (wb_adr_i == SCU_ADDR_CTRL && wb_sel_i[0])
        begin
          next_q.gie = wb_dat_i[SCU_CTRL_GIE_BIT];
          // Wake-up logic proper lives outside; this is its hook
          if (wb_dat_i[SCU_CTRL_WAKE_BIT])
          begin
            next_q.halt_sys = 1'b0;
            next_q.halt_core = 1'b0;
          end
        end
      end
      else
      begin
        unique case (wb_adr_i)
          SCU_ADDR_CTRL: next_q.rdata[SCU_CTRL_GIE_BIT] = q.gie;
          SCU_ADDR_STATUS:
          begin
            next_q.rdata[SCU_STAT_GIE_BIT] = q.gie;
            next_q.rdata[SCU_STAT_HSYS_BIT] = q.halt_sys;
            next_q.rdata[SCU_STAT_HCORE_BIT] = q.halt_core;
            next_q.rdata[SCU_STAT_RET2_BIT] = (q.st == SCU_ST_RET2);
          end
          SCU_ADDR_PC: next_q.rdata[PC_W-1:0] = q.pc;
          SCU_ADDR_SP: next_q.rdata[SP_W-1:0] = q.sp;
          default: next_q.rdata = '0;
        endcase
      end
    end

    // Instruction sequencing; instruction effects come after the bus
    // so a hardware set of the enable wins over a software write
    unique case (q.st)
      SCU_ST_IDLE:
      begin
        if (take)
        begin
          unique case (op)
            SCU_OP_CALL:
            begin
              ram_we = 1'b1;
              next_q.pc = instr_target_i;
              next_q.sp = sp_up;
              next_q.st = SCU_ST_JUMP2;
            end
            SCU_OP_JUMP:
            begin
              next_q.pc = instr_target_i;
              next_q.st = SCU_ST_JUMP2;
            end
            SCU_OP_PC_ADD:
            begin
              // Unsigned add, wraps within program space
              next_q.pc = q.pc + PC_W'(working_register_i);
              next_q.st = SCU_ST_JUMP2;
            end
            SCU_OP_RET, SCU_OP_RET_VAL, SCU_OP_RET_INT:
            begin
              // Pop now; the entry is read out next cycle
              next_q.sp = sp_dn;
              next_q.ret_int = (op == SCU_OP_RET_INT);
              next_q.st = SCU_ST_RET2;
              if (op == SCU_OP_RET_VAL)
              begin
                next_q.acc_we = 1'b1;
                next_q.acc = instr_imm_i;
              end
            end
            SCU_OP_GIE_ON:
            begin
              next_q.gie = 1'b1;
              next_q.pc = pc_seq;
            end
            SCU_OP_GIE_OFF:
            begin
              next_q.gie = 1'b0;
              next_q.pc = pc_seq;
            end
            SCU_OP_WDT_CLEAR:
            begin
              next_q.wdt_clr = 1'b1;
              next_q.pc = pc_seq;
            end
            SCU_OP_HALT_SYS:
            begin
              next_q.halt_sys = 1'b1;
              next_q.pc = pc_seq;
            end
            SCU_OP_HALT_CORE:
            begin
              next_q.halt_core = 1'b1;
              next_q.pc = pc_seq;
            end
            SCU_OP_SW_RESET:
            begin
              // Same image as the reset pin, plus the chip-wide pulse
              next_q = rst_val;
              next_q.chip_rst = 1'b1;
              // A bus cycle in flight still gets its answer, else it hangs
              next_q.ack = bus_req;
            end
            SCU_OP_NOP:
            begin
              next_q.pc = pc_seq;
            end
            default:
            begin
              // Codes outside the group are not this unit's work
              next_q.pc = pc_seq;
            end
          endcase
        end
      end
      SCU_ST_JUMP2:
      begin
        next_q.flush = 1'b1;
        next_q.st = SCU_ST_IDLE;
      end
      SCU_ST_RET2:
      begin
        next_q.pc = ram_rdata;
        next_q.flush = 1'b1;
        next_q.st = SCU_ST_IDLE;
        if (q.ret_int)
        begin
          next_q.gie = 1'b1;
        end
      end
      default: next_q.st = SCU_ST_IDLE;
    endcase
  end

  // ************************************************************
  // State register
  // ************************************************************
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      q <= rst_val;
    end
    else
    begin
      q <= next_q;
    end
  end

  // ************************************************************
  // Outputs
  // ************************************************************
  always_comb
  begin
    pc_o = q.pc;
    stack_top_pointer_o = q.sp;
    fetch_flush_o = q.flush;
    working_register_we_o = q.acc_we;
    working_register_o = q.acc;
    flags_we_o = 1'b0;
    gie_o = q.gie;
    wdt_clear_o = q.wdt_clr;
    sys_halt_o = q.halt_sys;
    // Core clock is gated in either halt; sys_halt_o also flags a system halt
    core_clk_gate_o = q.halt_core || q.halt_sys;
    chip_reset_o = q.chip_rst;
    wb_dat_o = q.rdata;
    wb_ack_o = q.ack;
  end

endmodule // scu_ctrl_exec

`default_nettype wire

// >>> scu_pkg.sv
/*
 * Shared constants for the system-control instruction unit: operation
 * codes, register map, field positions, reset values and step sizes.
 * Assumes the decoder in front of the unit has already classified the
 * fetched word into one of the operation codes below.
 */
package scu_pkg;

  // ************************************************************
  // Operation codes of the control instruction group
  // ************************************************************
  typedef enum logic [3:0] {
    SCU_OP_NOP,       // No operation
    SCU_OP_CALL,      // Subroutine call
    SCU_OP_JUMP,      // Unconditional jump
    SCU_OP_RET,       // Subroutine return
    SCU_OP_RET_VAL,   // Return with immediate into working register
    SCU_OP_RET_INT,   // Return from interrupt service
    SCU_OP_PC_ADD,    // Computed jump
    SCU_OP_GIE_ON,    // Global interrupt enable
    SCU_OP_GIE_OFF,   // Global interrupt disable
    SCU_OP_HALT_SYS,  // Stop everything
    SCU_OP_HALT_CORE, // Stop only the core clock
    SCU_OP_SW_RESET,  // Whole-chip reset
    SCU_OP_WDT_CLEAR  // Restart watchdog count
  } scu_op_e;

  // ************************************************************
  // Execution sequencing
  // ************************************************************
  typedef enum logic [1:0] {
    SCU_ST_IDLE,      // First cycle of any instruction
    SCU_ST_JUMP2,     // Second cycle of jump, call, computed jump
    SCU_ST_RET2       // Second cycle of any of the three returns
  } scu_state_e;

  // ************************************************************
  // Register map (byte addresses, one word each)
  // ************************************************************
  localparam logic [3:0] SCU_ADDR_CTRL = 4'h0;   // Control, R/W
  localparam logic [3:0] SCU_ADDR_STATUS = 4'h4; // Status, RO
  localparam logic [3:0] SCU_ADDR_PC = 4'h8;     // Program counter, RO
  localparam logic [3:0] SCU_ADDR_SP = 4'hC;     // Stack pointer, RO

  // Control fields
  localparam int SCU_CTRL_GIE_BIT = 0;     // Writes the interrupt enable
  localparam int SCU_CTRL_WAKE_BIT = 1;    // Writing 1 releases a halt

  // Status fields
  localparam int SCU_STAT_GIE_BIT = 0;
  localparam int SCU_STAT_HSYS_BIT = 1;
  localparam int SCU_STAT_HCORE_BIT = 2;
  localparam int SCU_STAT_RET2_BIT = 3;

  // ************************************************************
  // Steps and reset values
  // ************************************************************
  localparam int SCU_SP_STEP = 2;          // Bytes per stacked address
  localparam int SCU_PC_STEP = 1;          // Words per instruction
  localparam logic SCU_GIE_RST = 1'b0;     // Interrupts off after reset

endpackage : scu_pkg

// >>> scu_stack_ram.sv
/*
 * Small return-address store for the control unit: one write port and
 * one read port, read data registered. Assumes one write and one read
 * per cycle at most, and that the caller keeps the pointer in range.
 */
`timescale 1ns/10ps
`default_nettype none

module scu_stack_ram
  import scu_pkg::*;
#(
  parameter int WIDTH = 12,              // Stored address width
  parameter int DEPTH = 8                // Number of return entries
) (
  input wire logic clk_i,
  input wire logic we_i,
  input wire logic [$clog2(DEPTH)-1:0] waddr_i,
  input wire logic [WIDTH-1:0] wdata_i,
  input wire logic [$clog2(DEPTH)-1:0] raddr_i,
  output logic [WIDTH-1:0] rdata_o
);

  // ************************************************************
  // Storage
  // ************************************************************
  logic [WIDTH-1:0] mem [DEPTH];         // No reset: contents are data

  // Write port and registered read port
  always_ff @(posedge clk_i)
  begin
    if (we_i)
    begin
      mem[waddr_i] <= wdata_i;
    end
    rdata_o <= mem[raddr_i];
  end

endmodule // scu_stack_ram

`default_nettype wire

// >>> scu_ctrl_exec_monitor.sv
/* Concurrent checks on the instruction side of scu_ctrl_exec.
   Assumes it is bound onto the unit: one clock, synchronous reset. */
`timescale 1ns/10ps
`default_nettype none
module scu_ctrl_exec_monitor
  import scu_pkg::*;
#(
  parameter int PC_W = 12,
  parameter int SP_W = 8
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic instr_valid_i,
  input wire logic instr_ready_o,
  input wire logic [3:0] instr_op_i,
  input wire logic [PC_W-1:0] instr_target_i,
  input wire logic [7:0] instr_imm_i,
  input wire logic [7:0] working_register_i,
  input wire logic [PC_W-1:0] pc_o,
  input wire logic [SP_W-1:0] stack_top_pointer_o,
  input wire logic fetch_flush_o,
  input wire logic working_register_we_o,
  input wire logic [7:0] working_register_o,
  input wire logic gie_o,
  input wire logic wdt_clear_o,
  input wire logic sys_halt_o,
  input wire logic core_clk_gate_o,
  input wire logic chip_reset_o
);
  // ********
  // Sequences
  // ********
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // Request taken with one code
  sequence take_s(logic [3:0] op);
    instr_valid_i && instr_ready_o && instr_op_i == op;
  endsequence
  // Any return taken
  sequence ret_s;
    instr_valid_i && instr_ready_o && instr_op_i inside {4'h3, 4'h4, 4'h5};
  endsequence
  // Second cycle refused, then flush with ready back
  sequence tail_s;
    !instr_ready_o ##1 (fetch_flush_o && instr_ready_o);
  endsequence
  // ********
  // Checks
  // ********
  call_push_a: assert property (take_s(SCU_OP_CALL) |=>
    pc_o == $past(instr_target_i) && stack_top_pointer_o ==
    SP_W'($past(stack_top_pointer_o) + 2) ##0 tail_s) else $error("call");
  jump_load_a: assert property (take_s(SCU_OP_JUMP) |=>
    pc_o == $past(instr_target_i) ##0 tail_s) else $error("jump");
  pc_add_a: assert property (take_s(SCU_OP_PC_ADD) |=>
    pc_o == PC_W'($past(pc_o) + $past(working_register_i)) ##0 tail_s)
    else $error("computed jump");
  ret_value_a: assert property (take_s(SCU_OP_RET_VAL) |=>
    working_register_we_o && working_register_o == $past(instr_imm_i))
    else $error("return value");
  ret_pop_a: assert property (ret_s |=>
    stack_top_pointer_o == SP_W'($past(stack_top_pointer_o) - 2)
    ##0 tail_s) else $error("return pop");
  reti_gie_a: assert property (take_s(SCU_OP_RET_INT) |=> ##1 gie_o)
    else $error("interrupt return enable");
  gie_set_a: assert property (take_s(SCU_OP_GIE_ON) |=> gie_o)
    else $error("enable on");
  gie_clear_a: assert property (take_s(SCU_OP_GIE_OFF) |=> !gie_o)
    else $error("enable off");
  wdt_kick_a: assert property (take_s(SCU_OP_WDT_CLEAR) |=> wdt_clear_o)
    else $error("watchdog clear");
  core_halt_a: assert property (take_s(SCU_OP_HALT_CORE) |=>
    core_clk_gate_o && !sys_halt_o && !instr_ready_o)
    else $error("core halt");
  sys_halt_a: assert property (take_s(SCU_OP_HALT_SYS) |=>
    sys_halt_o && core_clk_gate_o && !instr_ready_o) else $error("halt");
  soft_reset_a: assert property (take_s(SCU_OP_SW_RESET) |=>
    chip_reset_o && pc_o == '0 && !gie_o ##1 !chip_reset_o)
    else $error("software reset");
endmodule // scu_ctrl_exec_monitor

bind scu_ctrl_exec scu_ctrl_exec_monitor #(.PC_W(PC_W), .SP_W(SP_W)) i_mon (
  .clk_i, .rst_i, .instr_valid_i, .instr_ready_o, .instr_op_i,
  .instr_target_i, .instr_imm_i, .working_register_i, .pc_o,
  .stack_top_pointer_o, .fetch_flush_o, .working_register_we_o,
  .working_register_o, .gie_o, .wdt_clear_o, .sys_halt_o,
  .core_clk_gate_o, .chip_reset_o);
`default_nettype wire

// >>> tb_scu_ctrl_exec.sv
/* Self-checking bench for scu_ctrl_exec: random control instructions
   against a small model, bus accesses, halts and software reset.
   Assumes the unit, its package and its checker are compiled first. */
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, e, g) \
  begin \
    checks_done++; \
    if ((g) !== (e)) \
    begin \
      fails++; \
      $display("CHECK FAILED %s exp %0h got %0h", nm, e, g); \
    end \
  end
module tb_scu_ctrl_exec
  import scu_pkg::*;
();
  localparam int PC_W = 12;
  localparam int SP_W = 8;
  // ********
  // Stimulus, outputs, model
  // ********
  logic clk_i = 1'b0, rst_i = 1'b1, instr_valid_i = 1'b0;
  logic [3:0] instr_op_i = 4'h0, wb_adr_i = 4'h0, wb_sel_i = 4'h0;
  logic [PC_W-1:0] instr_target_i = '0, pc_o, m_pc = '0, stk[8];
  logic [7:0] instr_imm_i = 8'h00, working_register_i = 8'h00;
  logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0, wb_ack_o;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o, rd;
  logic instr_ready_o, fetch_flush_o, working_register_we_o, flags_we_o;
  logic gie_o, wdt_clear_o, sys_halt_o, core_clk_gate_o, chip_reset_o;
  logic [7:0] working_register_o;
  logic [SP_W-1:0] stack_top_pointer_o, m_sp = '0;
  logic m_gie = 1'b0;
  int fails = 0, checks_done = 0, depth = 0, seed = 32'hC985;

  scu_ctrl_exec #(.PC_W(PC_W), .SP_W(SP_W)) i_scu_ctrl_exec (
    .clk_i, .rst_i, .instr_valid_i, .instr_ready_o, .instr_op_i,
    .instr_target_i, .instr_imm_i, .working_register_i, .pc_o,
    .stack_top_pointer_o, .fetch_flush_o, .working_register_we_o,
    .working_register_o, .flags_we_o, .gie_o, .wdt_clear_o, .sys_halt_o,
    .core_clk_gate_o, .chip_reset_o, .wb_cyc_i, .wb_stb_i, .wb_we_i,
    .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o);

  // 50 MHz clock
  initial
  begin
    forever #10 clk_i = ~clk_i;
  end

  // Verdict and end of run
  task automatic end_of_test();
    if (fails == 0 && checks_done > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // Expected counter after any non-return instruction
  function automatic logic [PC_W-1:0] exp_pc(scu_op_e op,
      logic [PC_W-1:0] pc, logic [PC_W-1:0] tg, logic [7:0] w);
    case (op)
      SCU_OP_CALL, SCU_OP_JUMP: return tg;
      SCU_OP_PC_ADD: return PC_W'(pc + w);
      SCU_OP_SW_RESET: return '0;
      default: return PC_W'(pc + 1);
    endcase
  endfunction

  // ********
  // Bus and instruction drivers
  // ********
  // One classic cycle; the idle edge first keeps cycles apart
  task automatic wb(input logic we, input logic [3:0] adr,
                    input logic [3:0] sel, input logic [31:0] wd);
    @(posedge clk_i);
    {wb_cyc_i, wb_stb_i, wb_we_i} <= {2'b11, we};
    wb_adr_i <= adr;
    wb_sel_i <= sel;
    wb_dat_i <= wd;
    // Only the bench watchdog ends a wait for the answer
    do
    begin
      @(posedge clk_i);
    end
    while (wb_ack_o !== 1'b1);
    rd = wb_dat_o;
    {wb_cyc_i, wb_stb_i} <= 2'b00;
  endtask

  // Issue one instruction, update the model, compare effects
  task automatic issue(input scu_op_e op, input logic [PC_W-1:0] tg,
                       input logic [7:0] w, input logic [7:0] im);
    logic ret, two;
    logic [PC_W-1:0] e_pc;
    ret = op inside {SCU_OP_RET, SCU_OP_RET_VAL, SCU_OP_RET_INT};
    two = ret || op inside {SCU_OP_CALL, SCU_OP_JUMP, SCU_OP_PC_ADD};
    e_pc = exp_pc(op, m_pc, tg, w);
    @(posedge clk_i);
    instr_valid_i <= 1'b1;
    instr_op_i <= op;
    instr_target_i <= tg;
    working_register_i <= w;
    instr_imm_i <= im;
    do
    begin
      @(posedge clk_i);
    end
    while (instr_ready_o !== 1'b1);
    instr_valid_i <= 1'b0;
    if (op == SCU_OP_CALL)
      stk[m_sp[3:1]] = PC_W'(m_pc + 1);
    // Only calls push and only returns pop; jumps leave the stack alone
    m_sp = (op == SCU_OP_SW_RESET) ? '0 : SP_W'(m_sp
           + SCU_SP_STEP * (op == SCU_OP_CALL) - SCU_SP_STEP * ret);
    depth = (op == SCU_OP_SW_RESET) ? 0 : depth + (op == SCU_OP_CALL) - ret;
    if (op inside {SCU_OP_GIE_ON, SCU_OP_GIE_OFF, SCU_OP_SW_RESET})
      m_gie = (op == SCU_OP_GIE_ON);
    @(posedge clk_i);
    `CHK("sp", m_sp, stack_top_pointer_o)
    `CHK("wdt", op == SCU_OP_WDT_CLEAR, wdt_clear_o)
    `CHK("reset", op == SCU_OP_SW_RESET, chip_reset_o)
    `CHK("wr we", op == SCU_OP_RET_VAL, working_register_we_o)
    if (op == SCU_OP_RET_VAL) `CHK("wr", im, working_register_o)
    `CHK("flags", 1'b0, flags_we_o)
    `CHK("flush", 1'b0, fetch_flush_o)
    if (!ret) `CHK("pc", e_pc, pc_o)
    `CHK("ready", !two && op < SCU_OP_HALT_SYS || op > SCU_OP_HALT_CORE
         && !two, instr_ready_o)
    if (two)
    begin
      @(posedge clk_i);
      `CHK("flush", 1'b1, fetch_flush_o)
      if (ret) `CHK("pc", stk[m_sp[3:1]], pc_o)
      m_gie = m_gie || op == SCU_OP_RET_INT;
    end
    `CHK("gie", m_gie, gie_o)
    m_pc = ret ? stk[m_sp[3:1]] : e_pc;
  endtask

  // ********
  // Main sequence and watchdog
  // ********
  initial
  begin
    int r;
    scu_op_e op;
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    `CHK("reset image", 21'h1, {pc_o, stack_top_pointer_o, instr_ready_o})
    wb(1'b1, SCU_ADDR_CTRL, 4'hE, 32'h1);
    wb(1'b1, SCU_ADDR_PC, 4'hF, 32'h123);
    wb(1'b0, SCU_ADDR_CTRL, 4'hF, 32'h0);
    `CHK("ctrl", 32'h0, rd)
    wb(1'b1, SCU_ADDR_CTRL, 4'hF, 32'h1);
    m_gie = 1'b1;
    wb(1'b0, 4'h2, 4'hF, 32'h0);
    `CHK("unmapped", 32'h0, rd)
    for (int i = 0; i < 80; i++)
    begin
      r = $unsigned($random(seed)) % 10;
      op = (r == 9) ? SCU_OP_WDT_CLEAR : scu_op_e'(r);
      if (op inside {SCU_OP_RET, SCU_OP_RET_VAL, SCU_OP_RET_INT})
        op = (depth == 0) ? SCU_OP_CALL : op;
      op = (op == SCU_OP_CALL && depth == 8) ? SCU_OP_RET : op;
      issue(op, (i % 7 == 0) ? '1 : PC_W'($random(seed)),
            8'($random(seed)), 8'($random(seed)));
    end
    wb(1'b0, SCU_ADDR_PC, 4'hF, 32'h0);
    `CHK("pc reg", 32'(m_pc), rd)
    issue(SCU_OP_HALT_SYS, '0, 8'h00, 8'h00);
    `CHK("sys halt", 2'b11, {sys_halt_o, core_clk_gate_o})
    wb(1'b0, SCU_ADDR_STATUS, 4'hF, 32'h0);
    `CHK("status", {1'b1, m_gie}, rd[1:0])
    wb(1'b1, SCU_ADDR_CTRL, 4'hF, {30'h0, 1'b1, m_gie});
    issue(SCU_OP_HALT_CORE, '0, 8'h00, 8'h00);
    `CHK("core halt", 2'b01, {sys_halt_o, core_clk_gate_o})
    wb(1'b1, SCU_ADDR_CTRL, 4'hF, 32'h3);
    `CHK("woken", 1'b1, instr_ready_o)
    m_gie = 1'b1;
    issue(SCU_OP_CALL, 12'h5A5, 8'h00, 8'h00);
    issue(SCU_OP_SW_RESET, '0, 8'h00, 8'h00);
    end_of_test();
  end

  // Hang guard, far beyond the expected run length
  initial
  begin
    repeat (5000) @(posedge clk_i);
    fails++;
    end_of_test();
  end
endmodule // tb_scu_ctrl_exec
`default_nettype wire
